// ---- core/rbs_boot_copy.sv ----
// rbs_boot_copy: copies the boot image byte by byte from the rom and
// writes packed 32-bit words from address zero.
// assumes rom_rdata is valid ROM_ACCESS_CYC cycles after the read strobe.
module rbs_boot_copy
  import rbs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                go,
  input  wire logic                big_endian,
  output logic                     rom_rd,
  output logic [IMAGE_AW-1:0]      rom_addr,
  input  wire logic [7:0]          rom_rdata,
  output rbs_mem_wr_t              mem_wr,
  output logic                     busy,
  output logic                     done
);

  typedef enum logic [2:0] {CP_IDLE, CP_READ, CP_WAIT, CP_DONE} rbs_cp_st_t;

  rbs_cp_st_t          st_q, st_d;
  logic [IMAGE_AW-1:0] idx_q, idx_d;
  logic [3:0]          wait_q, wait_d;
  logic [31:0]         word_q, word_d;
  logic                rd_q, rd_d;
  rbs_mem_wr_t         wr_q, wr_d;

  // byte lane of a given byte within its word, per endianness
  function automatic logic [31:0] rbs_place(input logic [31:0] w,
      input logic [7:0] b, input logic [1:0] k, input logic be);
    logic [1:0] lane;
    logic [31:0] r;
    lane = be ? 2'(2'h3 - k) : k;
    r = w;
    r[{lane, 3'h0} +: 8] = b;
    return r;
  endfunction

  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q;
    wait_d = wait_q;
    word_d = word_q;
    rd_d   = 1'b0;
    wr_d   = '0;
    case (st_q)
      CP_IDLE: begin
        if (go) begin
          st_d  = CP_READ;
          idx_d = '0;
        end
      end
      CP_READ: begin
        rd_d   = 1'b1;
        wait_d = '0;
        st_d   = CP_WAIT;
      end
      CP_WAIT: begin
        if (wait_q == ROM_WAIT_LAST) begin
          word_d = rbs_place(word_q, rom_rdata, idx_q[1:0], big_endian);
          if (idx_q[1:0] == 2'h3) begin
            wr_d.en   = 1'b1;
            wr_d.addr = COPY_DEST_ADDR + {22'h0, idx_q[9:2], 2'h0};
            wr_d.data = word_d;
          end
          if (idx_q == IMAGE_AW'(IMAGE_BYTES - 1)) begin
            st_d = CP_DONE;
          end else begin
            idx_d = idx_q + 1'b1;
            st_d  = CP_READ;
          end
        end else begin
          wait_d = wait_q + 1'b1;
        end
      end
      CP_DONE: st_d = CP_DONE;
      default: st_d = CP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= CP_IDLE;
      idx_q  <= '0;
      wait_q <= '0;
      word_q <= '0;
      rd_q   <= 1'b0;
      wr_q   <= '0;
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      wait_q <= wait_d;
      word_q <= word_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
    end
  end

  assign rom_rd   = rd_q;
  assign rom_addr = idx_q;
  assign mem_wr   = wr_q;
  assign busy     = (st_q == CP_READ) || (st_q == CP_WAIT) || wr_q.en;
  assign done     = (st_q == CP_DONE) && !wr_q.en;

endmodule // rbs_boot_copy

// ---- core/rbs_boot_seq.sv ----
// rbs_boot_seq: reset and boot sequencer top, with the host-side register
// port, the boot copy engine and the test reset logic.
// assumes straps are steady around reset release and a combinational
// memory read (mem_rdata follows mem_addr in the same cycle).
module rbs_boot_seq
  import rbs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,

  input  wire logic [1:0]          boot_mode_pin,
  input  wire logic                pci_sel_pin,
  input  wire logic                pci_present,
  input  wire logic                big_endian_pin,

  input  wire logic [REG_AW-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,

  input  wire logic                cpu_irq_clr,
  output logic                     cpu_stall,
  output logic                     cpu_start,
  output logic [31:0]              cpu_start_addr,
  output logic                     cpu_irq,
  output logic                     periph_rst_n,
  output logic                     host_on_pci,

  output logic                     rom_rd,
  output logic [IMAGE_AW-1:0]      rom_addr,
  input  wire logic [7:0]          rom_rdata,

  output logic                     mem_wr,
  output logic [31:0]              mem_addr,
  output logic [31:0]              mem_wdata,
  input  wire logic [31:0]         mem_rdata,

  input  wire logic                trst_in,
  input  wire logic                trst_driven,
  input  wire logic                emulation_cfg_pin_hi,
  input  wire logic                emulation_cfg_pin_lo,

  output logic                     test_rst_n,
  output logic                     idcode_variant_ok,
  output logic [1:0]               emu_mode,
  output logic                     emu_latched
);

  typedef enum logic [2:0] {
    ST_CAPTURE,
    ST_HOST_STALL,
    ST_COPY,
    ST_RUN
  } rbs_state_t;

  rbs_state_t    state_q, state_d;
  rbs_straps_t   straps_q, straps_d;

  logic          irq_q, irq_d;
  logic          start_q, start_d;
  logic          copy_go_q, copy_go_d;

  logic [31:0]   haddr_q, haddr_d;
  rbs_mem_wr_t   mem_q, mem_d;
  logic [31:0]   rdata_q, rdata_d;

  logic          copy_busy;
  logic          copy_done;
  rbs_mem_wr_t   copy_wr;
  logic [31:0]   status_w;
  logic          irq_set;

  // one register offset hit
  function automatic logic rbs_hit(input logic [REG_AW-1:0] a,
      input logic [REG_AW-1:0] r);
    return a == r;
  endfunction

  // read mux: unmapped offsets read zero rather than a stale word
  function automatic logic [31:0] rbs_read_mux(
      input logic [REG_AW-1:0] a,
      input logic              flag,
      input logic [31:0]       status,
      input logic [31:0]       waddr,
      input logic [31:0]       mdata);
    logic [31:0] r;
    r = '0;
    case (a)
      REG_HPC:      r[HPC_IRQ_BIT] = flag;
      REG_STATUS:   r = status;
      REG_MEM_ADDR: r = waddr;
      REG_MEM_DATA: r = mdata;
      default:      r = '0;
    endcase
    return r;
  endfunction

  rbs_boot_copy u_copy (
    .clk        (clk),
    .rst_n      (rst_n),
    .go         (copy_go_q),
    .big_endian (straps_q.big_endian),
    .rom_rd     (rom_rd),
    .rom_addr   (rom_addr),
    .rom_rdata  (rom_rdata),
    .mem_wr     (copy_wr),
    .busy       (copy_busy),
    .done       (copy_done)
  );

  rbs_test_latch u_test (
    .clk                  (clk),
    .rst_n                (rst_n),
    .trst_in              (trst_in),
    .trst_driven          (trst_driven),
    .emulation_cfg_pin_hi (emulation_cfg_pin_hi),
    .emulation_cfg_pin_lo (emulation_cfg_pin_lo),
    .test_rst_n           (test_rst_n),
    .idcode_variant_ok    (idcode_variant_ok),
    .emu_mode             (emu_mode),
    .emu_latched          (emu_latched)
  );

  // host writes a one to the flag bit; writing zero does nothing
  assign irq_set = reg_wr && rbs_hit(reg_addr, REG_HPC)
                   && reg_wdata[HPC_IRQ_BIT];

  // status word; unused bits read as zero
  always_comb begin
    status_w = '0;
    status_w[ST_MODE_LSB +: 2]    = straps_q.boot_mode;
    status_w[ST_PCI_BIT]          = straps_q.host_on_pci;
    status_w[ST_STALL_BIT]        = (state_q != ST_RUN);
    status_w[ST_COPYDN_BIT]       = copy_done;
    status_w[ST_EMULAT_BIT]       = emu_latched;
    status_w[ST_EMUMODE_LSB +: 2] = emu_mode;
    status_w[ST_ENDIAN_BIT]       = straps_q.big_endian;
    status_w[ST_RUN_BIT]          = (state_q == ST_RUN);
  end

  // straps are caught once, in the capture cycle, and held until reset
  always_comb begin
    straps_d = straps_q;
    if (state_q == ST_CAPTURE) begin
      straps_d.boot_mode   = boot_mode_pin;
      straps_d.host_on_pci = pci_present & pci_sel_pin;
      straps_d.big_endian  = big_endian_pin;
    end
  end

  // boot sequence; the capture state lasts one cycle and branches on boot_mode_pin
  // directly, in the same cycle that the straps are caught
  always_comb begin
    state_d   = state_q;
    start_d   = 1'b0;
    copy_go_d = 1'b0;
    case (state_q)
      ST_CAPTURE: begin
        case (boot_mode_pin)
          BOOT_HOST: state_d = ST_HOST_STALL;
          BOOT_EXTERNAL_MEMORY_PORT: begin
            state_d   = ST_COPY;
            copy_go_d = 1'b1;
          end
          default: begin
            state_d = ST_RUN;
            start_d = 1'b1;
          end
        endcase
      end
      ST_HOST_STALL: begin
        if (irq_q) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_COPY: begin
        if (copy_done) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_CAPTURE;
    endcase
  end

  // host interrupt flag: a set in the clearing cycle wins
  always_comb begin
    irq_d = irq_q;
    if (cpu_irq_clr) begin
      irq_d = 1'b0;
    end
    if (irq_set) begin
      irq_d = 1'b1;
    end
  end

  // memory window for the host; the copy engine owns the port while busy
  always_comb begin
    haddr_d = haddr_q;
    mem_d   = '0;
    rdata_d = '0;
    if (copy_busy) begin
      mem_d = copy_wr;
    end else if (reg_wr && rbs_hit(reg_addr, REG_MEM_DATA)) begin
      mem_d.en   = 1'b1;
      mem_d.addr = haddr_q;
      mem_d.data = reg_wdata;
      haddr_d    = haddr_q + MEM_ADDR_STEP;
    end
    if (reg_wr && rbs_hit(reg_addr, REG_MEM_ADDR)) begin
      haddr_d = reg_wdata;
    end
    // an idle port points at the window address, so a data read sees the
    // word there one cycle later without an extra fetch cycle
    if (!mem_d.en) begin
      mem_d.addr = haddr_d;
    end
    if (reg_rd) begin
      rdata_d = rbs_read_mux(reg_addr, irq_q, status_w, haddr_q, mem_rdata);
    end
  end

  // boot state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= ST_CAPTURE;
      start_q   <= 1'b0;
      copy_go_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      start_q   <= start_d;
      copy_go_q <= copy_go_d;
    end
  end

  // captured straps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      straps_q <= '0;
    end else begin
      straps_q <= straps_d;
    end
  end

  // host interrupt flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // host memory window and read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      haddr_q <= MEM_ADDR_RST;
      mem_q   <= '0;
      rdata_q <= '0;
    end else begin
      haddr_q <= haddr_d;
      mem_q   <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  // stall covers reset too, so the cpu never sees a half-captured mode
  assign cpu_stall      = (state_q != ST_RUN);
  assign cpu_start      = start_q;
  assign cpu_start_addr = EXEC_START_ADDR;
  assign cpu_irq        = irq_q;
  assign periph_rst_n   = rst_n;
  assign host_on_pci    = straps_q.host_on_pci;
  assign mem_wr         = mem_q.en;
  assign mem_addr       = mem_q.addr;
  assign mem_wdata      = mem_q.data;
  assign reg_rdata      = rdata_q;

endmodule // rbs_boot_seq

// ---- core/rbs_pkg.sv ----
// rbs_pkg: constants and carrier types of the reset and boot sequencer.
// assumes a single 10 MHz clock; all straps and pins are synchronous to it.
package rbs_pkg;

  // boot modes on the two strap pins; the fourth code falls back to no boot
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_HOST = 2'h1;
  localparam logic [1:0] BOOT_EXTERNAL_MEMORY_PORT = 2'h2;

  // register map of the plain host-side register port (byte offsets)
  localparam int          REG_AW       = 4;
  localparam logic [3:0]  REG_HPC      = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_MEM_ADDR = 4'h8;
  localparam logic [3:0]  REG_MEM_DATA = 4'hC;

  // field positions
  localparam int HPC_IRQ_BIT    = 0;
  localparam int ST_MODE_LSB    = 0;
  localparam int ST_PCI_BIT     = 2;
  localparam int ST_STALL_BIT   = 3;
  localparam int ST_COPYDN_BIT  = 4;
  localparam int ST_EMULAT_BIT  = 5;
  localparam int ST_EMUMODE_LSB = 6;
  localparam int ST_ENDIAN_BIT  = 8;
  localparam int ST_RUN_BIT     = 9;

  // reset value, start and copy addresses, window address step
  localparam logic [31:0] MEM_ADDR_RST    = 32'h0000_0000;
  localparam logic [31:0] EXEC_START_ADDR = 32'h0000_0000;
  localparam logic [31:0] COPY_DEST_ADDR  = 32'h0000_0000;
  localparam logic [31:0] MEM_ADDR_STEP   = 32'h0000_0004;

  // boot image copied from the start of chip select space 1
  localparam int          IMAGE_BYTES = 1024;
  localparam int          IMAGE_AW    = 10;

  // default rom access timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          ROM_ACCESS_NS = 250;
  localparam int          ROM_ACCESS_CYC =
    (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  ROM_WAIT_LAST = 4'(ROM_ACCESS_CYC - 1);

  typedef struct packed {
    logic [1:0] boot_mode;
    logic       host_on_pci;
    logic       big_endian;
  } rbs_straps_t;

  typedef struct packed {
    logic        en;
    logic [31:0] addr;
    logic [31:0] data;
  } rbs_mem_wr_t;

endpackage : rbs_pkg

// ---- core/rbs_test_latch.sv ----
// rbs_test_latch: test reset with internal pull-down, and latching of the
// emulation configuration pins on every test reset rise after boot.
// assumes trst and emulation pins are synchronous to clk.
module rbs_test_latch
  import rbs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       trst_in,
  input  wire logic       trst_driven,
  input  wire logic       emulation_cfg_pin_hi,
  input  wire logic       emulation_cfg_pin_lo,
  output logic            test_rst_n,
  output logic            idcode_variant_ok,
  output logic [1:0]      emu_mode,
  output logic            emu_latched
);

  logic       trst_eff;
  logic       trst_prev_q, trst_prev_d;
  logic [1:0] mode_q, mode_d;
  logic       lat_q, lat_d;

  // an undriven pin reads low, so test logic stays in reset
  assign trst_eff = trst_driven & trst_in;

  always_comb begin
    trst_prev_d = trst_eff;
    mode_d      = mode_q;
    lat_d       = lat_q;
    if (trst_eff && !trst_prev_q) begin
      mode_d = {emulation_cfg_pin_hi, emulation_cfg_pin_lo};
      lat_d  = 1'b1;
    end
  end

  // device reset clears the latched mode; a fresh rise is needed afterwards
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trst_prev_q <= 1'b1;
      mode_q      <= 2'h0;
      lat_q       <= 1'b0;
    end else begin
      trst_prev_q <= trst_prev_d;
      mode_q      <= mode_d;
      lat_q       <= lat_d;
    end
  end

  assign test_rst_n        = trst_eff;
  assign idcode_variant_ok = rst_n;
  assign emu_mode          = mode_q;
  assign emu_latched       = lat_q;

endmodule // rbs_test_latch

// ---- sim/rbs_boot_seq_chk.sv ----
// rbs_boot_seq_chk: port assertions of the reset and boot sequencer.
// assumes straps stay steady while the core runs.
module rbs_boot_seq_chk
  import rbs_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [1:0]        boot_mode_pin,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              cpu_irq_clr,
  input wire logic              cpu_stall,
  input wire logic              cpu_start,
  input wire logic [31:0]       cpu_start_addr,
  input wire logic              cpu_irq,
  input wire logic              rom_rd,
  input wire logic              trst_in,
  input wire logic              trst_driven,
  input wire logic              emulation_cfg_pin_hi,
  input wire logic              emulation_cfg_pin_lo,
  input wire logic              test_rst_n,
  input wire logic              idcode_variant_ok,
  input wire logic [1:0]        emu_mode,
  input wire logic              emu_latched
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_host_flag;
    $rose(cpu_irq) && cpu_stall && boot_mode_pin == BOOT_HOST;
  endsequence
  sequence s_release;
    !cpu_stall && cpu_start;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) !rst_n |=>
    cpu_stall && !cpu_start && !cpu_irq && !rom_rd && reg_rdata == 32'h0)
    else $error("state not at reset value");
  a_host_release: assert property (s_host_flag |=> s_release)
    else $error("host flag did not release the cpu");
  a_flag_ignored: assert property ($rose(cpu_irq) && cpu_stall &&
    boot_mode_pin != BOOT_HOST |=> cpu_stall)
    else $error("flag released the cpu outside host boot");
  a_start_zero: assert property (cpu_start |->
    $fell(cpu_stall) && cpu_start_addr == EXEC_START_ADDR)
    else $error("start without stall fall or not at zero");
  a_stall_stays: assert property (!cpu_stall |=> !cpu_stall)
    else $error("cpu stalled again without reset");
  a_irq_hold: assert property (cpu_irq && !cpu_irq_clr |=> cpu_irq)
    else $error("flag dropped without clear");
  a_irq_clear: assert property (cpu_irq_clr &&
    !(reg_wr && reg_addr == REG_HPC) |=> !cpu_irq)
    else $error("flag not cleared");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_rom_wait: assert property (rom_rd |=> !rom_rd [*3])
    else $error("rom strobes too close");
  a_rom_stall: assert property (rom_rd |-> cpu_stall)
    else $error("rom read while cpu runs");
  a_trst_pull: assert property (!trst_driven |-> !test_rst_n)
    else $error("undriven test reset not low");
  a_idcode_ok: assert property (disable iff (1'b0)
    idcode_variant_ok == rst_n)
    else $error("idcode variant state wrong");
  a_emu_latch: assert property ($rose(trst_in && trst_driven) &&
    !emu_latched |-> ##[1:2] (emu_latched &&
    emu_mode == {emulation_cfg_pin_hi, emulation_cfg_pin_lo}))
    else $error("emulation pins not latched");
endmodule // rbs_boot_seq_chk

bind rbs_boot_seq rbs_boot_seq_chk i_chk (.*);

// ---- sim/rbs_far_model.sv ----
// rbs_far_model: boot rom on select space 1 and the word memory at zero.
// assumes the core takes a rom byte within three cycles of its strobe.
module rbs_far_model
  import rbs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rom_rd,
  input  wire logic [IMAGE_AW-1:0] rom_addr,
  output logic      [7:0]          rom_rdata,
  input  wire logic                mem_wr,
  input  wire logic [31:0]         mem_addr,
  input  wire logic [31:0]         mem_wdata,
  output logic      [31:0]         mem_rdata
);
  logic [31:0]         mem [256];
  logic [IMAGE_AW-1:0] a_q = 10'h0;
  logic [1:0]          cnt_q = 2'h0;
  function automatic logic [7:0] rom_byte(input logic [9:0] n);
    return n[7:0] ^ {n[9:8], 6'h2A};
  endfunction
  // outside the access window the byte is inverted, never left stale
  assign rom_rdata = (cnt_q != 2'h0) ? rom_byte(a_q) : ~rom_byte(a_q);
  assign mem_rdata = mem[mem_addr[9:2]];
  always @(posedge clk) begin
    if (rom_rd) begin
      a_q <= rom_addr;
      cnt_q <= 2'h3;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
    if (mem_wr) begin
      mem[mem_addr[9:2]] <= mem_wdata;
    end
  end
endmodule // rbs_far_model

// ---- sim/tb_top.sv ----
// tb_top: self-checking bench of the reset and boot sequencer.
// assumes the far model serves the rom and the word memory.
module tb_top
  import rbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [1:0] boot_mode_pin = 2'h0, emu_mode;
  logic pci_sel_pin = 1'h0, pci_present = 1'h0, big_endian_pin = 1'h0;
  logic [REG_AW-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, cpu_start_addr;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic cpu_irq_clr = 1'h0, trst_in = 1'h0, trst_driven = 1'h0;
  logic emulation_cfg_pin_hi = 1'h0, emulation_cfg_pin_lo = 1'h0;
  logic cpu_stall, cpu_start, cpu_irq, periph_rst_n, host_on_pci;
  logic rom_rd, mem_wr, test_rst_n, idcode_variant_ok, emu_latched;
  logic [IMAGE_AW-1:0] rom_addr;
  logic [7:0] rom_rdata;
  int n_fail = 0, cmp_count = 0, n_start = 0, n_rom = 0;

  rbs_boot_seq i_dut (.*);
  rbs_far_model i_far (.*);

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (cpu_start === 1'h1) n_start++;
    if (rom_rd === 1'h1) n_rom++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // clock keeps running through reset, test reset stays low
  task automatic do_reset(input logic [1:0] m, input logic pp, ps, be);
    @(posedge clk);
    rst_n <= 1'h0;
    boot_mode_pin <= m;
    pci_present <= pp;
    pci_sel_pin <= ps;
    big_endian_pin <= be;
    nap(4);
    chk(cpu_stall, 1);
    chk(periph_rst_n, 0);
    chk(idcode_variant_ok, 0);
    n_start = 0;
    n_rom = 0;
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic t_noboot();
    for (int i = 0; i < 2; i++) begin
      do_reset(i ? 2'h3 : BOOT_NONE, 1'h0, 1'h0, 1'h0);
      nap(4);
      chk(n_start, 1);
      chk(cpu_stall, 0);
      chk(n_rom, 0);
      chk(idcode_variant_ok, 1);
    end
    $display("test noboot done");
  endtask
  task automatic t_host();
    logic [31:0] d;
    for (int i = 1; i < 4; i++) begin
      do_reset(BOOT_HOST, i[1], i[0], 1'h0);
      pci_sel_pin <= ~pci_sel_pin;
      nap(2);
      chk(host_on_pci, i == 3);
    end
    rd(REG_STATUS, d);
    chk(d[1:0], BOOT_HOST);
    wr(REG_MEM_ADDR, 32'h0000_0040);
    wr(REG_MEM_DATA, 32'hA5C3_0F1E);
    rd(REG_MEM_ADDR, d);
    chk(d, 32'h0000_0044);
    chk(i_far.mem[16], 32'hA5C3_0F1E);
    wr(REG_MEM_ADDR, 32'h0000_0040);
    rd(REG_MEM_DATA, d);
    chk(d, 32'hA5C3_0F1E);
    chk(cpu_stall, 1);
    chk(periph_rst_n, 1);
    wr(REG_HPC, 32'h0000_0001);
    nap(3);
    chk(n_start, 1);
    chk(cpu_stall, 0);
    $display("test host done");
  endtask
  task automatic t_rom(input logic be);
    int lim;
    logic [31:0] w;
    do_reset(BOOT_EXTERNAL_MEMORY_PORT, 1'h0, 1'h0, be);
    wr(REG_HPC, 32'h0000_0001);
    nap(4);
    chk(cpu_stall, 1);
    lim = 5000;
    while (n_start == 0 && lim > 0) begin
      @(posedge clk);
      lim--;
    end
    nap(1);
    chk(n_start, 1);
    chk(n_rom, IMAGE_BYTES);
    for (int i = 0; i < 256; i += 85) begin
      for (int k = 0; k < 4; k++)
        w[8*(be ? 3-k : k) +: 8] = i_far.rom_byte(10'(4*i+k));
      chk(i_far.mem[i], w);
    end
    chk(cpu_irq, 1);
    @(posedge clk);
    cpu_irq_clr <= 1'h1;
    @(posedge clk);
    cpu_irq_clr <= 1'h0;
    nap(1);
    chk(cpu_irq, 0);
    $display("test rom done");
  endtask
  task automatic t_emu();
    do_reset(BOOT_NONE, 1'h0, 1'h0, 1'h0);
    nap(3);
    chk(n_start, 1);
    chk(emu_latched, 0);
    @(posedge clk);
    trst_driven <= 1'h1;
    emulation_cfg_pin_hi <= 1'h1;
    @(posedge clk);
    trst_in <= 1'h1;
    nap(3);
    chk(test_rst_n, 1);
    chk(emu_latched, 1);
    chk(emu_mode, 2'h2);
    @(posedge clk);
    trst_driven <= 1'h0;
    nap(1);
    chk(test_rst_n, 0);
    $display("test emulation done");
  endtask

  initial begin
    t_noboot();
    t_host();
    t_rom(1'h0);
    t_rom(1'h1);
    t_emu();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule // tb_top
